// File: hw/lgp_pkg.sv
// Purpose: shared constants and types for the lcd-shared gpio ports a and b
// Assumes: wishbone classic slave, 32-bit data, byte addresses
// Notes: register words carry their data in the low bits, upper bits zero
package lgp_pkg;

	// =========================================================
	// widths
	localparam int LGP_PA_W = 8; // port a pins
	localparam int LGP_PB_W = 5; // port b pins, bits 7:5 unimplemented
	localparam int LGP_ADR_W = 8; // wishbone byte address width
	localparam int LGP_DAT_W = 32; // wishbone data width

	// =========================================================
	// register byte offsets
	localparam logic [7:0] LGP_OFF_A_LATCH = 8'h00; // port_a_output_latch
	localparam logic [7:0] LGP_OFF_A_DIR = 8'h04; // port_a_direction
	localparam logic [7:0] LGP_OFF_B_LATCH = 8'h08; // port_b_output_latch
	localparam logic [7:0] LGP_OFF_B_DIR = 8'h0C; // port_b_direction
	// read_modify_write views of the latches: always return the latch
	localparam logic [7:0] LGP_OFF_A_LATCH_RMW = 8'h20;
	localparam logic [7:0] LGP_OFF_B_LATCH_RMW = 8'h28;

	// =========================================================
	// reset values
	localparam logic [7:0] LGP_RST_DIR_A = 8'h00; // all inputs
	localparam logic [4:0] LGP_RST_DIR_B = 5'h00; // all inputs
	localparam logic [7:0] LGP_RST_LATCH_A = 8'h00;
	localparam logic [4:0] LGP_RST_LATCH_B = 5'h00;

	// =========================================================
	// carriers
	// wishbone classic request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [LGP_ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [LGP_DAT_W-1:0] dat;
	} lgp_wb_req_t;

	// lcd controller function select and drive levels
	typedef struct packed {
		logic [LGP_PA_W-1:0] com_select; // 1 = pin to lcd common
		logic [LGP_PB_W-1:0] seg_select; // 1 = pin to lcd segment
		logic port_input_control; // handover completion bit
		logic [LGP_PA_W-1:0] com_drive; // lcd common levels
		logic [LGP_PB_W-1:0] seg_drive; // lcd segment levels
	} lgp_lcd_t;

	// whole state of the port block
	typedef struct packed {
		logic [LGP_PA_W-1:0] pa_sync1;
		logic [LGP_PA_W-1:0] pa_sync2;
		logic [LGP_PB_W-1:0] pb_sync1;
		logic [LGP_PB_W-1:0] pb_sync2;
		logic [LGP_PA_W-1:0] pa_latch;
		logic [LGP_PA_W-1:0] pa_dir;
		logic [LGP_PB_W-1:0] pb_latch;
		logic [LGP_PB_W-1:0] pb_dir;
		logic [LGP_PA_W-1:0] pa_out;
		logic [LGP_PA_W-1:0] pa_oe;
		logic [LGP_PB_W-1:0] pb_out;
		logic [LGP_PB_W-1:0] pb_oe;
		logic ack;
		logic [LGP_DAT_W-1:0] dat_o;
	} lgp_state_t;

	localparam lgp_state_t LGP_RST_STATE = '{
		pa_sync1: 8'h00, pa_sync2: 8'h00,
		pb_sync1: 5'h00, pb_sync2: 5'h00,
		pa_latch: LGP_RST_LATCH_A, pa_dir: LGP_RST_DIR_A,
		pb_latch: LGP_RST_LATCH_B, pb_dir: LGP_RST_DIR_B,
		pa_out: 8'h00, pa_oe: 8'h00,
		pb_out: 5'h00, pb_oe: 5'h00,
		ack: 1'b0, dat_o: 32'h0000_0000
	};

endpackage : lgp_pkg

// File: hw/lgp_ports.sv
// Purpose: gpio ports a (8 pins) and b (5 pins) shared with lcd outputs
// Assumes: one clock mclk, synchronous active-high rst, wishbone classic
// Notes: pads are split into in, out and output enable
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps

// Function
// - direction bit 1 makes the pin output
// - direction bit 0 makes the pin input
// - output pin drives its latch bit
// - writes update latch; input pins stay undriven
// - normal read of output bit returns latch
// - normal read of input bit returns pin
// - read_modify_write read always returns latch
// - bit 0 is low, bit 1 is high
// - reset clears all direction bits to input
// - standby with float bit floats every pin
// - floated pins read as low internally
// - float bit 0 keeps pin state in standby
// - common select 1 hands port a pin to lcd
// - common select 0 keeps port a pin gpio
// - segment select 1 hands port b pin to lcd
// - segment select 0 keeps port b pin gpio
// - port a has eight pins, bits 0 to 7
// - port b has five pins, bits 0 to 4
module lgp_ports (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// wishbone classic slave
	input lgp_pkg::lgp_wb_req_t wb_req,
	output logic [lgp_pkg::LGP_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// lcd controller side
	input lgp_pkg::lgp_lcd_t lcd,
	// standby control
	input wire logic standby_active,
	input wire logic standby_pin_float,
	// port a pads
	input wire logic [lgp_pkg::LGP_PA_W-1:0] pa_in,
	output logic [lgp_pkg::LGP_PA_W-1:0] pa_out,
	output logic [lgp_pkg::LGP_PA_W-1:0] pa_oe,
	// port b pads
	input wire logic [lgp_pkg::LGP_PB_W-1:0] pb_in,
	output logic [lgp_pkg::LGP_PB_W-1:0] pb_out,
	output logic [lgp_pkg::LGP_PB_W-1:0] pb_oe
);
	import lgp_pkg::*;

	// =========================================================
	// state and combinational helpers
	lgp_state_t st; // registered state
	lgp_state_t next_st; // next state
	logic flt; // pins floated by standby
	logic req; // bus cycle active
	logic new_req; // request not yet answered
	logic wr; // write takes effect at this edge
	logic [LGP_PA_W-1:0] pa_val; // gated port a input value
	logic [LGP_PB_W-1:0] pb_val; // gated port b input value
	logic [LGP_PA_W-1:0] pa_rd; // port a normal read value
	logic [LGP_PB_W-1:0] pb_rd; // port b normal read value

	// =========================================================
	// next-state logic
	always_comb begin
		next_st = st;
		// standby float only when the float bit is set
		flt = standby_active & standby_pin_float;
		// two-stage synchronisers on the pads
		next_st.pa_sync1 = pa_in;
		next_st.pa_sync2 = st.pa_sync1;
		next_st.pb_sync1 = pb_in;
		next_st.pb_sync2 = st.pb_sync1;
		// input gating: floated pins read low, lcd pins blocked while port_input_control is set
		pa_val = flt ? '0 : st.pa_sync2 &
			~(lcd.com_select & {LGP_PA_W{lcd.port_input_control}});
		pb_val = flt ? '0 : st.pb_sync2 &
			~(lcd.seg_select & {LGP_PB_W{lcd.port_input_control}});
		// per bit: latch for outputs, pin for inputs
		pa_rd = (st.pa_dir & st.pa_latch) | (~st.pa_dir & pa_val);
		pb_rd = (st.pb_dir & st.pb_latch) | (~st.pb_dir & pb_val);
		// bus handshake: answer one cycle after the request
		req = wb_req.cyc & wb_req.stb;
		new_req = req & ~st.ack;
		next_st.ack = new_req;
		wr = req & st.ack & wb_req.we & wb_req.sel[0];
		// register writes at the edge the master sees ack
		if (wr) begin
			case (wb_req.adr)
				LGP_OFF_A_LATCH: next_st.pa_latch = wb_req.dat[7:0];
				LGP_OFF_A_DIR: next_st.pa_dir = wb_req.dat[7:0];
				LGP_OFF_B_LATCH: next_st.pb_latch = wb_req.dat[4:0];
				LGP_OFF_B_DIR: next_st.pb_dir = wb_req.dat[4:0];
				default: begin
					// unmapped: write ignored
				end
			endcase
		end
		// read data prepared with ack, zero otherwise
		next_st.dat_o = '0;
		if (new_req && !wb_req.we) begin
			case (wb_req.adr)
				LGP_OFF_A_LATCH: next_st.dat_o[7:0] = pa_rd;
				LGP_OFF_A_DIR: next_st.dat_o[7:0] = st.pa_dir;
				LGP_OFF_B_LATCH: next_st.dat_o[4:0] = pb_rd;
				LGP_OFF_B_DIR: next_st.dat_o[4:0] = st.pb_dir;
				LGP_OFF_A_LATCH_RMW: next_st.dat_o[7:0] = st.pa_latch;
				LGP_OFF_B_LATCH_RMW: next_st.dat_o[4:0] = st.pb_latch;
				default: begin
					// unmapped: reads zero
				end
			endcase
		end
		// port a and b pads: lcd common or segment, gpio or float
		if (flt) begin
			next_st.pa_oe = '0;
			next_st.pa_out = '0;
			next_st.pb_oe = '0;
			next_st.pb_out = '0;
		end else begin
			next_st.pa_oe = lcd.com_select |
				(~lcd.com_select & next_st.pa_dir);
			next_st.pa_out = (lcd.com_select & lcd.com_drive) |
				(~lcd.com_select & next_st.pa_latch);
			next_st.pb_oe = lcd.seg_select |
				(~lcd.seg_select & next_st.pb_dir);
			next_st.pb_out = (lcd.seg_select & lcd.seg_drive) |
				(~lcd.seg_select & next_st.pb_latch);
		end
	end

	// =========================================================
	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= LGP_RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	// =========================================================
	// outputs straight from flip-flops
	assign wb_dat_o = st.dat_o;
	assign wb_ack_o = st.ack;
	assign pa_out = st.pa_out;
	assign pa_oe = st.pa_oe;
	assign pb_out = st.pb_out;
	assign pb_oe = st.pb_oe;

	// =========================================================
	// assertions
	sequence req_start_s;
		wb_req.cyc && wb_req.stb && !st.ack;
	endsequence

	sequence rd_a_s;
		req_start_s and (!wb_req.we && wb_req.adr == LGP_OFF_A_LATCH);
	endsequence

	sequence rmw_a_s;
		req_start_s and (!wb_req.we && wb_req.adr == LGP_OFF_A_LATCH_RMW);
	endsequence

	sequence wr_b_s;
		wb_req.cyc && wb_req.stb && st.ack && wb_req.we &&
			wb_req.sel[0] && wb_req.adr == LGP_OFF_B_LATCH;
	endsequence

	bus_ack_once_a: assert property (@(posedge mclk) disable iff (rst)
		req_start_s |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	dir_reset_a: assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> st.pa_dir == 8'h00 && st.pb_dir == 5'h00 &&
			pa_oe == 8'h00 && pb_oe == 5'h00)
		else $error("direction not cleared by reset");

	oe_select_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(flt) |->
			pa_oe == ($past(lcd.com_select) | st.pa_dir))
		else $error("port a enable mismatch");

	out_level_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(flt) |-> pb_out ==
			(($past(lcd.seg_select) & $past(lcd.seg_drive)) |
			(~$past(lcd.seg_select) & st.pb_latch)))
		else $error("port b pad level mismatch");

	float_pins_a: assert property (@(posedge mclk) disable iff (rst)
		flt |=> pa_oe == 8'h00 && pb_oe == 5'h00)
		else $error("pins not floated in standby");

	normal_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_a_s |=> wb_dat_o[7:0] == $past(pa_rd) &&
			wb_dat_o[31:8] == 24'h000000)
		else $error("port a read value wrong");

	rmw_read_a: assert property (@(posedge mclk) disable iff (rst)
		rmw_a_s |=> wb_dat_o[7:0] == $past(st.pa_latch))
		else $error("rmw read not latch");

	float_input_a: assert property (@(posedge mclk) disable iff (rst)
		flt |-> pa_val == 8'h00 && pb_val == 5'h00)
		else $error("floated input not low");

	latch_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_b_s |=> st.pb_latch == $past(wb_req.dat[4:0]))
		else $error("port b latch not written");

	hold_state_a: assert property (@(posedge mclk) disable iff (rst)
		standby_active && !standby_pin_float && $stable(lcd) && !wr
			&& !$past(rst) && !$past(flt) |=>
			$stable(pa_oe) && $stable(pa_out))
		else $error("pin state changed in standby");

	// =========================================================
	// further checks, grouped by the side they guard
	// pad and sync properties that look one edge back skip the first
	// edge after reset through a past-reset term; bus, read and write ones do not

	// ---- bus side sequences ---------------------------------
	// no request on the bus this cycle
	sequence idle_bus_s;
		!(wb_req.cyc && wb_req.stb);
	endsequence

	// any read just taken by the slave
	sequence rd_any_s;
		req_start_s and !wb_req.we;
	endsequence

	// any write landing at this edge
	sequence wr_any_s;
		wb_req.cyc && wb_req.stb && st.ack && wb_req.we &&
			wb_req.sel[0];
	endsequence

	// address outside the register map
	sequence unmapped_s;
		wb_req.adr != LGP_OFF_A_LATCH && wb_req.adr != LGP_OFF_A_DIR &&
			wb_req.adr != LGP_OFF_B_LATCH && wb_req.adr != LGP_OFF_B_DIR &&
			wb_req.adr != LGP_OFF_A_LATCH_RMW &&
			wb_req.adr != LGP_OFF_B_LATCH_RMW;
	endsequence

	// ---- bus handshake --------------------------------------
	// an idle bus is never answered
	idle_no_ack_a: assert property (@(posedge mclk) disable iff (rst)
		idle_bus_s |=> !wb_ack_o)
		else $error("ack without request");

	// ack never stands two cycles in a row
	ack_single_a: assert property (@(posedge mclk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack stood two cycles");

	// every ack follows a request one edge earlier
	ack_cause_a: assert property (@(posedge mclk) disable iff (rst)
		wb_ack_o |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack not caused by request");

	// read data is zero outside the ack cycle
	dat_idle_a: assert property (@(posedge mclk) disable iff (rst)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	// ---- register reads -------------------------------------
	// port a direction reads back as written
	dir_a_read_a: assert property (@(posedge mclk) disable iff (rst)
		(rd_any_s and wb_req.adr == LGP_OFF_A_DIR) |=>
			wb_dat_o[7:0] == $past(st.pa_dir) &&
			wb_dat_o[31:8] == 24'h000000)
		else $error("port a direction read wrong");

	// port b direction reads back, bits 7:5 zero
	dir_b_read_a: assert property (@(posedge mclk) disable iff (rst)
		(rd_any_s and wb_req.adr == LGP_OFF_B_DIR) |=>
			wb_dat_o[4:0] == $past(st.pb_dir) &&
			wb_dat_o[31:5] == 27'h0000000)
		else $error("port b direction read wrong");

	// output bits of a normal read carry the latch
	out_bit_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_a_s |=> (wb_dat_o[7:0] & $past(st.pa_dir)) ==
			($past(st.pa_latch) & $past(st.pa_dir)))
		else $error("output bit read not latch");

	// input bits of a normal read carry the gated pin
	in_bit_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_a_s |=> (wb_dat_o[7:0] & ~$past(st.pa_dir)) ==
			($past(pa_val) & ~$past(st.pa_dir)))
		else $error("input bit read not pin");

	// port b normal read, upper bits zero
	normal_b_read_a: assert property (@(posedge mclk) disable iff (rst)
		(rd_any_s and wb_req.adr == LGP_OFF_B_LATCH) |=>
			wb_dat_o[4:0] == $past(pb_rd) &&
			wb_dat_o[31:5] == 27'h0000000)
		else $error("port b read value wrong");

	// port b rmw view always shows the latch
	rmw_b_read_a: assert property (@(posedge mclk) disable iff (rst)
		(rd_any_s and wb_req.adr == LGP_OFF_B_LATCH_RMW) |=>
			wb_dat_o[4:0] == $past(st.pb_latch) &&
			wb_dat_o[31:5] == 27'h0000000)
		else $error("port b rmw read not latch");

	// unmapped addresses read as zero
	unmapped_read_a: assert property (@(posedge mclk) disable iff (rst)
		(rd_any_s and unmapped_s) |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ---- register writes ------------------------------------
	// port a latch takes the low byte
	wr_a_latch_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_any_s and wb_req.adr == LGP_OFF_A_LATCH) |=>
			st.pa_latch == $past(wb_req.dat[7:0]))
		else $error("port a latch not written");

	// port a direction takes the low byte
	wr_a_dir_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_any_s and wb_req.adr == LGP_OFF_A_DIR) |=>
			st.pa_dir == $past(wb_req.dat[7:0]))
		else $error("port a direction not written");

	// unmapped writes leave every register alone
	unmapped_wr_a: assert property (@(posedge mclk) disable iff (rst)
		(wr_any_s and unmapped_s) |=> $stable(st.pa_latch) &&
			$stable(st.pa_dir) && $stable(st.pb_latch) &&
			$stable(st.pb_dir))
		else $error("unmapped write changed a register");

	// without a write the registers hold
	reg_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr |=> $stable(st.pa_latch) && $stable(st.pa_dir) &&
			$stable(st.pb_latch) && $stable(st.pb_dir))
		else $error("register changed without write");

	// ---- reset ----------------------------------------------
	// pads and handshake quiet after reset
	reset_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> pa_out == 8'h00 && pb_out == 5'h00 &&
			!wb_ack_o)
		else $error("outputs not quiet after reset");

	// ---- pads -----------------------------------------------
	// floated pins also drive a low level
	float_out_a: assert property (@(posedge mclk) disable iff (rst)
		flt |=> pa_out == 8'h00 && pb_out == 5'h00)
		else $error("floated pad level not low");

	// lcd-owned port a pads show the common level
	com_drive_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(flt) |->
			(pa_out & $past(lcd.com_select)) ==
			($past(lcd.com_drive) & $past(lcd.com_select)))
		else $error("lcd common level not on pad");

	// gpio-owned port a pads show the latch
	gpio_out_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(flt) |->
			(pa_out & ~$past(lcd.com_select)) ==
			(st.pa_latch & ~$past(lcd.com_select)))
		else $error("port a latch not on pad");

	// port b enable: segment select or direction
	oe_b_select_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) && !$past(flt) |->
			pb_oe == ($past(lcd.seg_select) | st.pb_dir))
		else $error("port b enable mismatch");

	// port b pads hold through standby without float
	hold_b_state_a: assert property (@(posedge mclk) disable iff (rst)
		standby_active && !standby_pin_float && $stable(lcd) && !wr
			&& !$past(rst) && !$past(flt) |=>
			$stable(pb_oe) && $stable(pb_out))
		else $error("port b state changed in standby");

	// ---- input path -----------------------------------------
	// handed-over pins are blocked once input control is set
	lcd_block_a: assert property (@(posedge mclk) disable iff (rst)
		lcd.port_input_control |->
			(pa_val & lcd.com_select) == 8'h00 &&
			(pb_val & lcd.seg_select) == 5'h00)
		else $error("lcd pin input not blocked");

	// gpio pins pass the synchronised level
	gpio_input_a: assert property (@(posedge mclk) disable iff (rst)
		!flt |-> (pa_val & ~lcd.com_select) ==
			(st.pa_sync2 & ~lcd.com_select))
		else $error("gpio input not passed");

	// second sync stage only follows the first
	sync_chain_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) |-> st.pa_sync2 == $past(st.pa_sync1) &&
			st.pb_sync2 == $past(st.pb_sync1))
		else $error("input synchroniser skipped a stage");

endmodule : lgp_ports

// File: test/lgp_pad_model.sv
// Purpose: pad and external driver model for one port
// Assumes: no pull resistor on the pads
// Notes: a pad nobody drives toggles every cycle
`timescale 1ns/1ps
module lgp_pad_model #(
	parameter int W = 8
) (
	// clock
	input wire logic mclk,
	// design pad side
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe,
	output logic [W-1:0] pad_in,
	// external driver
	input wire logic [W-1:0] ext_val,
	input wire logic [W-1:0] ext_en
);
	// =========================================
	// floating level, never a steady value
	logic [W-1:0] flip = '0;
	always @(posedge mclk) begin
		flip <= ~flip;
	end
	// wire level from all drivers
	always_comb begin
		pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
			| (~pad_oe & ~ext_en & flip);
	end
endmodule : lgp_pad_model

// File: test/testbench.sv
// Purpose: self-checking bench for the lcd-shared ports
// Assumes: one bus request at a time
// Notes: pads resolved by the pad model
`timescale 1ns/1ps
module testbench;
	import lgp_pkg::*;
	// =========================================
	// stimulus and observed signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	lgp_wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	lgp_lcd_t lcd = '0;
	logic standby_active = 1'b0;
	logic standby_pin_float = 1'b0;
	logic [7:0] pa_in, pa_out, pa_oe, ea_v = 8'h3C, ea_en = 8'hFF;
	logic [4:0] pb_in, pb_out, pb_oe;
	logic [31:0] rd;
	int num_errors = 0;
	int cmp_count = 0;
	always #5 mclk = ~mclk;
	lgp_ports lgp_ports_inst (.mclk(mclk), .rst(rst), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lcd(lcd),
		.standby_active(standby_active),
		.standby_pin_float(standby_pin_float), .pa_in(pa_in),
		.pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
		.pb_oe(pb_oe));
	lgp_pad_model #(.W(8)) pad_a_inst (.mclk(mclk), .pad_out(pa_out),
		.pad_oe(pa_oe), .pad_in(pa_in), .ext_val(ea_v), .ext_en(ea_en));
	lgp_pad_model #(.W(5)) pad_b_inst (.mclk(mclk), .pad_out(pb_out),
		.pad_oe(pb_oe), .pad_in(pb_in), .ext_val(5'h00), .ext_en(5'h00));
	// =========================================
	// verdict, compare and bus tasks
	task automatic stop_test();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one classic cycle, waits for ack under a bound
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hF, dat:d};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			$display("[ERR] bus ack expected 1 seen timeout");
			stop_test();
		end
		rd = wb_dat_o;
		wb_req <= '0;
	endtask : bus
	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk
	// let pads and input sync settle
	task automatic settle();
		repeat (4) @(posedge mclk);
		#1;
	endtask : settle
	// =========================================
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rdchk("dir a", LGP_OFF_A_DIR, 32'h0);
		rdchk("dir b", LGP_OFF_B_DIR, 32'h0);
		bus(1'b1, LGP_OFF_A_LATCH, 32'hA5);
		settle();
		chk("oe a input", 32'h0, pa_oe);
		rdchk("pin a", LGP_OFF_A_LATCH, 32'h3C);
		rdchk("rmw a", LGP_OFF_A_LATCH_RMW, 32'hA5);
		// low nibble output, high nibble driven from outside
		ea_en <= 8'hF0;
		bus(1'b1, LGP_OFF_A_DIR, 32'h0F);
		settle();
		chk("oe a mix", 32'h0F, pa_oe);
		chk("out a", 32'h05, pa_out & pa_oe);
		chk("pin level a", 32'h35, pa_in);
		rdchk("mix a", LGP_OFF_A_LATCH, 32'h35);
		// port b, upper bits unimplemented
		bus(1'b1, LGP_OFF_B_LATCH, 32'hFF);
		bus(1'b1, LGP_OFF_B_DIR, 32'hFF);
		settle();
		chk("oe b", 32'h1F, pb_oe);
		chk("out b", 32'h1F, pb_out);
		rdchk("dir b all", LGP_OFF_B_DIR, 32'h1F);
		bus(1'b1, 8'h40, 32'hFF);
		rdchk("unmapped", 8'h40, 32'h0);
		rdchk("rmw b", LGP_OFF_B_LATCH_RMW, 32'h1F);
		// standby without and with floating
		standby_active <= 1'b1;
		settle();
		chk("oe a hold", 32'h0F, pa_oe);
		standby_pin_float <= 1'b1;
		settle();
		chk("oe a float", 32'h0, pa_oe);
		chk("oe b float", 32'h0, pb_oe);
		rdchk("gated a", LGP_OFF_A_LATCH, 32'h05);
		standby_active <= 1'b0;
		standby_pin_float <= 1'b0;
		// hand pins to the lcd, directions cleared first
		bus(1'b1, LGP_OFF_A_DIR, 32'h0);
		bus(1'b1, LGP_OFF_B_DIR, 32'h0);
		ea_en <= 8'h0F;
		lcd <= '{com_select:8'hF0, seg_select:5'h13,
			port_input_control:1'b1, com_drive:8'hAA, seg_drive:5'h1F};
		settle();
		chk("oe a lcd", 32'hF0, pa_oe);
		chk("out a lcd", 32'hA0, pa_out & 8'hF0);
		chk("oe b lcd", 32'h13, pb_oe);
		chk("out b lcd", 32'h13, pb_out & 5'h13);
		rdchk("blocked a", LGP_OFF_A_LATCH, 32'h0C);
		lcd.com_select <= 8'h00;
		lcd.seg_select <= 5'h00;
		settle();
		chk("oe a gpio", 32'h0, pa_oe);
		chk("oe b gpio", 32'h0, pb_oe);
		stop_test();
	end
endmodule : testbench
